//--- rtl/ssxap_pkg.sv
// package: constants and carrier types for the single-step and external access port
package ssxap_pkg;
	// address and data widths
	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	localparam int PORT_W = 8;
	localparam int P2LO_W = 2;
	// instruction cycle: clocks per cycle and position of the sync pulse
	localparam int CYC_LEN    = 15;
	localparam int SYNC_START = 10;
	localparam int SYNC_MID   = 12;
	localparam int FETCH_PH   = 2;
	// reset fetch addresses in external access
	localparam logic [9:0] ROM_FIRST_PC  = 10'h0ff;
	localparam logic [9:0] ROM_SECOND_PC = 10'h001;
	localparam logic [9:0] EPROM_FIRST_PC = 10'h000;
	localparam logic [9:0] PC_RESET      = 10'h000;
	// host buffer access window, nanoseconds, and clock period
	localparam int HOST_WIN_NS = 600;
	localparam int CLK_NS      = 4;
	localparam int HOST_WIN_CYC = HOST_WIN_NS / CLK_NS;
	// step state machine states
	typedef enum logic [1:0] {
		SSXAP_RUN,
		SSXAP_DRAIN,
		SSXAP_HALT
	} ssxap_step_e;
	// values bundled toward the ports
	typedef struct packed {
		logic [7:0] p1;
		logic [1:0] p2lo;
	} ssxap_port_s;
endpackage

//--- rtl/ssxap_sync2.sv
// two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module ssxap_sync2 #(
	parameter int W   = 1,
	parameter bit RST = 1'b0
) (
	// clock and reset
	input  wire logic         i_sys_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_ce,
	// pins in, synced out
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_r;
	// first stage read only by the second
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_r <= {W{RST}};
			o_q    <= {W{RST}};
		end else if (i_ce) begin
			meta_r <= i_d;
			o_q    <= meta_r;
		end
	end
endmodule

//--- rtl/ssxap_verify.sv
// address latch and verify readout of program memory
`timescale 1ns/1ps
module ssxap_verify
	import ssxap_pkg::*;
(
	// clock and reset
	input  wire logic              i_sys_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_ce,
	// synced programmer pins
	input  wire logic              i_program_pulse_pin_en,
	input  wire logic              i_reset_pin,
	input  wire logic              i_verify_sel,
	input  wire logic [DATA_W-1:0] i_data,
	input  wire logic [P2LO_W-1:0] i_p2lo,
	// memory read and readout
	output logic      [ADDR_W-1:0] o_addr,
	input  wire logic [DATA_W-1:0] i_word,
	output logic      [DATA_W-1:0] o_data,
	output logic                   o_drive
);
	import ssxap_pkg::*;
	logic reset_d_r;
	// rising reset pin latches the address
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			reset_d_r <= 1'b0;
			o_addr    <= '0;
		end else if (i_ce) begin
			reset_d_r <= i_reset_pin;
			if (i_program_pulse_pin_en && i_reset_pin && !reset_d_r)
				o_addr <= {i_p2lo, i_data};
		end
	end
	// verify high with reset held drives the stored word; low is program mode
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_data  <= '0;
			o_drive <= 1'b0;
		end else if (i_ce) begin
			o_drive <= i_program_pulse_pin_en && reset_d_r && i_verify_sel;
			o_data  <= i_word;
		end
	end
endmodule

//--- rtl/ssxap_top.sv
// single-step, external access and verify port logic of the microcontroller
`timescale 1ns/1ps
module ssxap_top
	import ssxap_pkg::*;
#(
	parameter bit EPROM_VARIANT = 1'b1
) (
	// clock, reset, enable
	input  wire logic              i_sys_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_ce,
	// pins from outside
	input  wire logic              i_step_req_n,
	input  wire logic              i_external_access,
	input  wire logic              i_reset_pin,
	input  wire logic              i_verify_sel,
	input  wire logic [DATA_W-1:0] i_data,
	input  wire logic [P2LO_W-1:0] i_p2lo_pin,
	// core side, same clock
	input  wire logic              i_two_cycle,
	input  wire logic [ADDR_W-1:0] i_core_next_pc,
	input  wire ssxap_port_s       i_core_port,
	input  wire logic [DATA_W-1:0] i_int_opcode,
	input  wire logic [DATA_W-1:0] i_rom_word,
	// outputs
	output logic                   o_cycle_sync,
	output logic                   o_halted,
	output logic                   o_advance,
	output logic                   o_fetch,
	output logic [ADDR_W-1:0]      o_pc,
	output logic [DATA_W-1:0]      o_opcode,
	output ssxap_port_s            o_port,
	output logic                   o_host_ok,
	output logic [ADDR_W-1:0]      o_mem_addr,
	output logic [DATA_W-1:0]      o_data,
	output logic                   o_data_oe_n
);
	import ssxap_pkg::*;

	initial begin
		if (SYNC_MID <= SYNC_START || SYNC_MID >= CYC_LEN || FETCH_PH >= SYNC_START)
			$error("bad cycle phase constants");
	end

	// synchronised pins
	logic              step_n_s, ea_s, rp_s, vs_s;
	logic [DATA_W-1:0] data_s;
	logic [P2LO_W-1:0] p2lo_s;
	ssxap_sync2 #(.W(4), .RST(1'b1)) u_sync_ctl (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.i_ce      (i_ce),
		.i_d       ({i_step_req_n, i_external_access, i_reset_pin, i_verify_sel}),
		.o_q       ({step_n_s, ea_s, rp_s, vs_s})
	);
	ssxap_sync2 #(.W(DATA_W + P2LO_W), .RST(1'b0)) u_sync_dat (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.i_ce      (i_ce),
		.i_d       ({i_p2lo_pin, i_data}),
		.o_q       ({p2lo_s, data_s})
	);

	// cycle phase counter and state
	logic [3:0]  phase_r;
	ssxap_step_e st_r;
	logic        req_r;
	logic        second_r;
	logic        halted;
	logic        cyc_end;
	assign halted  = (st_r == SSXAP_HALT);
	assign cyc_end = (phase_r == 4'(CYC_LEN - 1));

	// phase advances once per clock; frozen while halted
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			phase_r <= '0;
		end else if (i_ce && !halted) begin
			phase_r <= cyc_end ? 4'h0 : phase_r + 4'h1;
		end
	end

	// step request sampled mid-pulse
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			req_r <= 1'b0;
		end else if (i_ce) begin
			if (phase_r == 4'(SYNC_MID) && !halted)
				req_r <= !step_n_s;
			else if (halted)
				req_r <= 1'b0;
		end
	end

	// tracks second cycle of a two-cycle instruction
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			second_r <= 1'b0;
		end else if (i_ce && cyc_end && !halted) begin
			second_r <= i_two_cycle && !second_r;
		end
	end

	// step state machine: halt at next fetch boundary, release on high request
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= SSXAP_RUN;
		end else if (i_ce) begin
			unique case (st_r)
				SSXAP_RUN: begin
					if (cyc_end && req_r)
						st_r <= (i_two_cycle && !second_r) ? SSXAP_DRAIN : SSXAP_HALT;
				end
				SSXAP_DRAIN: begin
					if (cyc_end)
						st_r <= SSXAP_HALT;
				end
				SSXAP_HALT: begin
					if (step_n_s)
						st_r <= SSXAP_RUN;
				end
			endcase
		end
	end

	// cycle sync: pulse each cycle; while halted, high only while the step request is low
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_cycle_sync <= 1'b0;
			o_halted     <= 1'b0;
		end else if (i_ce) begin
			o_halted     <= halted;
			o_cycle_sync <= halted ? !step_n_s
				: (phase_r >= 4'(SYNC_START - 1) && phase_r < 4'(CYC_LEN - 1));
		end
	end

	// host buffer window: external access only, during the sync pulse phases or while halted
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_host_ok <= 1'b0;
		end else if (i_ce) begin
			o_host_ok <= ea_s && (halted || (phase_r >= 4'(SYNC_START - 1)
				&& phase_r < 4'(CYC_LEN - 1)));
		end
	end

	// reset fetch sequence in external access
	logic [1:0] boot_r;
	logic       fetch_now;
	assign fetch_now = !halted && (phase_r == 4'(FETCH_PH));
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			boot_r <= 2'h0;
		end else if (i_ce && fetch_now && boot_r != 2'h2) begin
			boot_r <= boot_r + 2'h1;
		end
	end

	// fetch address and opcode source
	logic [ADDR_W-1:0] pc_nxt;
	always_comb begin
		pc_nxt = i_core_next_pc;
		if (ea_s && boot_r == 2'h0)
			pc_nxt = EPROM_VARIANT ? EPROM_FIRST_PC : ROM_FIRST_PC;
		else if (ea_s && boot_r == 2'h1 && !EPROM_VARIANT)
			pc_nxt = ROM_SECOND_PC;
	end
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pc     <= PC_RESET;
			o_opcode <= '0;
			o_fetch  <= 1'b0;
			o_advance <= 1'b0;
		end else if (i_ce) begin
			o_fetch   <= fetch_now;
			o_advance <= cyc_end && !halted;
			if (fetch_now) begin
				o_pc     <= pc_nxt;
				o_opcode <= ea_s ? data_s : i_int_opcode;
			end
		end
	end

	// port mux: next address while halted; fetch address in external access (EPROM variant only before SYNC_START)
	logic mux_phase;
	assign mux_phase = (phase_r < 4'(SYNC_START));
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_port <= '0;
		end else if (i_ce) begin
			if (halted)
				o_port <= {i_core_next_pc[7:0], i_core_next_pc[9:8]};
			else if (ea_s && (!EPROM_VARIANT || mux_phase))
				o_port <= {o_pc[7:0], o_pc[9:8]};
			else
				o_port <= i_core_port;
		end
	end

	// program memory verify readout
	logic [DATA_W-1:0] vdata;
	logic              vdrive;
	ssxap_verify u_verify (
		.i_sys_clk   (i_sys_clk),
		.i_rst_n     (i_rst_n),
		.i_ce        (i_ce),
		.i_program_pulse_pin_en   (ea_s),
		.i_reset_pin (rp_s),
		.i_verify_sel(vs_s),
		.i_data      (data_s),
		.i_p2lo      (p2lo_s),
		.o_addr      (o_mem_addr),
		.i_word      (i_rom_word),
		.o_data      (vdata),
		.o_drive     (vdrive)
	);
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_data      <= '0;
			o_data_oe_n <= 1'b1;
		end else if (i_ce) begin
			o_data      <= vdata;
			o_data_oe_n <= !vdrive;
		end
	end

	// checks
	sequence s_req_mid;
		!halted && phase_r == 4'(SYNC_MID) && !step_n_s && i_ce;
	endsequence
	AST_SAMPLE_MID: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		s_req_mid |=> req_r) else $error("request not sampled");
	AST_FREE_RUN: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(st_r == SSXAP_RUN && !req_r && i_ce) |=> st_r == SSXAP_RUN)
		else $error("halted without request");
	AST_HALT_AT_END: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(st_r == SSXAP_RUN && req_r && cyc_end && !i_two_cycle && i_ce) |=> halted)
		else $error("no halt at cycle end");
	AST_DRAIN: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(st_r == SSXAP_DRAIN && !cyc_end && i_ce) |=> st_r == SSXAP_DRAIN)
		else $error("second cycle cut short");
	AST_SYNC_HALT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(halted && !step_n_s && i_ce) |=> o_cycle_sync) else $error("sync low while halted");
	AST_RELEASE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(halted && step_n_s && i_ce) |=> !halted) else $error("no release");
	AST_PULSE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(!halted && phase_r == 4'(SYNC_START) && i_ce) |=> o_cycle_sync)
		else $error("missing sync pulse");
	AST_HALT_PORT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(halted && i_ce) |=> o_port.p1 == $past(i_core_next_pc[7:0]))
		else $error("address not on port");
	AST_EA_OPCODE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(ea_s && fetch_now && i_ce) |=> o_opcode == $past(data_s))
		else $error("opcode not from data lines");
	AST_HOST_WIN: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		o_host_ok |-> (o_cycle_sync || !o_halted)) else $error("host window outside sync");
endmodule

//--- sim/ssxap_step_model.sv
// stepping circuit model that drives the active-low step request
`timescale 1ns/1ps
module ssxap_step_model (
	// clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_rst_n,
	// bench control
	input  wire logic i_step_mode,
	input  wire logic i_go,
	// device side
	input  wire logic i_cycle_sync,
	output logic      o_step_req_n
);
	logic sync_d_r;
	// delayed sync to find the trailing edge of each pulse
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) sync_d_r <= 1'b0;
		else sync_d_r <= i_cycle_sync;
	end
	// flip-flop style: preset in run, cleared only after sync has fallen
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_step_req_n <= 1'b1;
		end else if (!i_step_mode) begin
			o_step_req_n <= 1'b1;
		end else if (i_go && i_cycle_sync) begin
			o_step_req_n <= 1'b1;
		end else if (sync_d_r && !i_cycle_sync) begin
			o_step_req_n <= 1'b0;
		end
	end
endmodule

//--- sim/ssxap_top_tb.sv
// self-checking bench for the step, external access and verify port
`timescale 1ns/1ps
module ssxap_top_tb;
	import ssxap_pkg::*;
	localparam int LIMIT = 5000;
	// stimulus and observed signals
	logic              clk, rst_n, step_mode, go, ea, rpin, vsel, two_cyc;
	logic [7:0]        data, int_op, rom_word, opcode, dout;
	logic [1:0]        p2lo;
	logic [9:0]        next_pc, pc, mem_addr;
	ssxap_port_s       core_port, port;
	logic              step_n, sync, halted, fetch, oe_n, host_ok, adv;
	logic [9:0]        pc_rom;
	ssxap_port_s       port_rom;
	int                mismatches = 0;
	int                comparisons = 0;
	int                cycles = 0;
	int                k;
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	ssxap_top u_ssxap_top (.i_sys_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
		.i_step_req_n(step_n), .i_external_access(ea), .i_reset_pin(rpin),
		.i_verify_sel(vsel), .i_data(data), .i_p2lo_pin(p2lo), .i_two_cycle(two_cyc),
		.i_core_next_pc(next_pc), .i_core_port(core_port), .i_int_opcode(int_op),
		.i_rom_word(rom_word), .o_cycle_sync(sync), .o_halted(halted), .o_advance(adv),
		.o_fetch(fetch), .o_pc(pc), .o_opcode(opcode), .o_port(port), .o_host_ok(host_ok),
		.o_mem_addr(mem_addr), .o_data(dout), .o_data_oe_n(oe_n));
	// rom variant on the same pins: boot addresses and unmultiplexed ports
	ssxap_top #(.EPROM_VARIANT(1'b0)) u_ssxap_top_rom (.i_sys_clk(clk), .i_rst_n(rst_n),
		.i_ce(1'b1), .i_step_req_n(step_n), .i_external_access(ea), .i_reset_pin(rpin),
		.i_verify_sel(vsel), .i_data(data), .i_p2lo_pin(p2lo), .i_two_cycle(two_cyc),
		.i_core_next_pc(next_pc), .i_core_port(core_port), .i_int_opcode(int_op),
		.i_rom_word(rom_word), .o_cycle_sync(), .o_halted(), .o_advance(),
		.o_fetch(), .o_pc(pc_rom), .o_opcode(), .o_port(port_rom), .o_host_ok(),
		.o_mem_addr(), .o_data(), .o_data_oe_n());
	ssxap_step_model u_ssxap_step_model (.i_sys_clk(clk), .i_rst_n(rst_n),
		.i_step_mode(step_mode), .i_go(go), .i_cycle_sync(sync), .o_step_req_n(step_n));
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// hang guard: a run far past the expected length counts as a failure
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == LIMIT) begin
			mismatches++;
			end_of_test();
		end
	end
	task automatic chk_val(input logic [9:0] got, input logic [9:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_val({9'h000, got}, {9'h000, exp});
	endtask
	// wait n edges, then let that edge's updates settle
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic do_reset(input logic ea_v);
		@(posedge clk);
		ea <= ea_v;
		rst_n <= 1'b0;
		tick(3);
		chk_bit(oe_n, 1'b1);
		chk_bit(sync, 1'b0);
		@(posedge clk);
		rst_n <= 1'b1;
	endtask
	task automatic test_ea_boot();
		do_reset(1'b1);
		for (k = 0; k < 40 && fetch !== 1'b1; k++) tick(1);
		tick(3);
		chk_val(pc, EPROM_FIRST_PC);
		chk_val(port, {EPROM_FIRST_PC[7:0], EPROM_FIRST_PC[9:8]});
		chk_val({2'h0, opcode}, 10'h03c);
		chk_val(pc_rom, ROM_FIRST_PC);
		chk_bit(host_ok, 1'b0);
		for (k = 0; k < 20 && sync !== 1'b1; k++) tick(1);
		tick(2);
		chk_val(port, 10'h1e6);
		chk_val(port_rom, {ROM_FIRST_PC[7:0], ROM_FIRST_PC[9:8]});
		chk_bit(host_ok, 1'b1);
		for (k = 0; k < 20 && fetch !== 1'b1; k++) tick(1);
		tick(3);
		chk_val(pc_rom, ROM_SECOND_PC);
		$display("test ea_boot done");
	endtask
	task automatic test_verify();
		@(posedge clk);
		rpin <= 1'b0;
		tick(5);
		@(posedge clk);
		data <= 8'h5a;
		p2lo <= 2'h2;
		tick(5);
		@(posedge clk);
		rpin <= 1'b1;
		tick(8);
		chk_val(mem_addr, 10'h25a);
		chk_bit(oe_n, 1'b1);
		@(posedge clk);
		vsel <= 1'b1;
		tick(10);
		chk_bit(oe_n, 1'b0);
		chk_val({2'h0, dout}, 10'h0c3);
		$display("test verify done");
	endtask
	task automatic test_free_run();
		int ups;
		int highs;
		int halts;
		int advs;
		logic prev;
		do_reset(1'b0);
		tick(20);
		ups = 0;
		highs = 0;
		halts = 0;
		advs = 0;
		prev = sync;
		repeat (150) begin
			tick(1);
			ups += int'(sync && !prev);
			highs += int'(sync);
			halts += int'(halted);
			advs += int'(adv);
			prev = sync;
		end
		chk_val(10'(ups), 10'd10);
		chk_val(10'(highs), 10'd50);
		chk_val(10'(halts), 10'd0);
		chk_val(10'(advs), 10'h00a);
		$display("test free_run done");
	endtask
	task automatic test_step();
		@(posedge clk);
		step_mode <= 1'b1;
		for (k = 0; k < 60 && halted !== 1'b1; k++) tick(1);
		chk_bit(halted, 1'b1);
		chk_bit(sync, 1'b1);
		chk_val(port, {8'ha5, 2'h2});
		tick(40);
		chk_bit(halted, 1'b1);
		chk_bit(sync, 1'b1);
		@(posedge clk);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		for (k = 0; k < 10 && sync !== 1'b0; k++) tick(1);
		chk_bit(sync, 1'b0);
		// halted level trails the sync drop by one edge
		tick(1);
		chk_bit(halted, 1'b0);
		for (k = 0; k < 40 && halted !== 1'b1; k++) tick(1);
		chk_bit(halted, 1'b1);
		@(posedge clk);
		step_mode <= 1'b0;
		for (k = 0; k < 10 && halted !== 1'b0; k++) tick(1);
		chk_bit(halted, 1'b0);
		$display("test step done");
	endtask
	initial begin
		rst_n = 1'b0;
		step_mode = 1'b0;
		go = 1'b0;
		ea = 1'b1;
		rpin = 1'b1;
		vsel = 1'b0;
		two_cyc = 1'b0;
		data = 8'h3c;
		p2lo = 2'h0;
		int_op = 8'hc7;
		rom_word = 8'hc3;
		next_pc = 10'h2a5;
		core_port = 10'h1e6;
		test_ea_boot();
		test_verify();
		test_free_run();
		test_step();
		end_of_test();
	end
endmodule
